// ===== bench/lcc_far_end.sv
// Far link end: recovered clock, receive words and a note of each payload word.
// Assumes one lane; its 200 ns clock is free of the system clock.
`timescale 1ns/10ps
`include "lcc_defs.svh"
module lcc_far_end #(
    parameter int EVERY = 5
) (
    // Enable and line
    input wire logic i_en,
    output logic o_rec_clk,
    output logic [`LCC_LANE_W-1:0] o_word,
    // Note of each payload word, toggled per word
    output logic o_sent,
    output logic [`LCC_LANE_W-1:0] o_sent_word
);
    int n;
    initial begin
        o_rec_clk = 1'b0;
        o_word = '0;
        o_sent = 1'b0;
        o_sent_word = '0;
        n = 0;
    end
    always begin
        #100;
        if (i_en && !o_rec_clk) begin
            o_rec_clk = 1'b1;
            if (o_word != `LCC_COMP_WORD) begin
                o_sent_word = o_word;
                o_sent = ~o_sent;
            end
        end else begin
            // Word changes half a period from the rising edge
            o_rec_clk = 1'b0;
            n++;
            if (!i_en) o_word = ~o_word;
            else if (n % EVERY == 0) o_word = `LCC_COMP_WORD;
            else o_word = 16'(n);
        end
    end
endmodule : lcc_far_end

// ===== bench/lcc_top_sva.sv
// Checker for lcc_top, watching its ports only.
// Assumes a single system clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
`include "lcc_defs.svh"
module lcc_top_sva #(
    parameter int LANES = 1,
    parameter bit INDEP_CLOCKS = 1'b0,
    parameter bit TOL_100PPM = 1'b0,
    parameter int COMP_CYC_300 = `LCC_COMP_CYC_300PPM,
    parameter int COMP_CYC_100 = `LCC_COMP_CYC_100PPM
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Reset sequencer
    input wire logic o_pll_async_reset_out,
    input wire logic o_receiver_analog_reset_out,
    input wire logic o_link_ready,
    // Streams
    input wire logic o_tx_word_valid,
    input wire logic [LANES*`LCC_LANE_W-1:0] o_tx_word,
    input wire logic o_tx_comp_inserted,
    input wire logic o_rx_valid,
    input wire logic [LANES*`LCC_LANE_W-1:0] o_rx_data,
    input wire logic o_rx_comp_dropped
);
    localparam int PER = TOL_100PPM ? COMP_CYC_100 : COMP_CYC_300;
    logic [12:0] gap_reg;
    logic [1:0] nins_reg;
    // First gap after link ready may be short, since a held request goes out late
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !o_link_ready) begin
            gap_reg <= 13'h0;
            nins_reg <= 2'h0;
        end else if (o_tx_comp_inserted) begin
            gap_reg <= 13'h0;
            if (nins_reg != 2'h2) nins_reg <= nins_reg + 2'h1;
        end else begin
            gap_reg <= gap_reg + 13'h1;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    chk_rst_all_held: assert property ($rose(i_rst_n) |-> o_pll_async_reset_out &&
        o_receiver_analog_reset_out && !o_link_ready) else $error("resets not held");
    chk_pll_rst_hold: assert property ($rose(i_rst_n) |-> ##39 o_pll_async_reset_out)
        else $error("pll reset short");
    chk_rx_rst_order: assert property (o_pll_async_reset_out |-> o_receiver_analog_reset_out)
        else $error("rx reset before pll");
    chk_rx_rst_hold: assert property ($fell(o_pll_async_reset_out) |->
        ##38 o_receiver_analog_reset_out) else $error("rx reset short");
    // Ready and the end of the receiver reset leave the same edge
    chk_ready_clean: assert property (o_link_ready |-> !o_pll_async_reset_out &&
        !o_receiver_analog_reset_out &&
        ($past(o_link_ready) || $past(o_receiver_analog_reset_out)))
        else $error("ready during reset");
    // Words are registered, so one may still leave in the cycle after ready falls
    chk_tx_when_ready: assert property (o_tx_word_valid |-> $past(o_link_ready))
        else $error("tx word before ready");
    chk_comp_word: assert property (o_tx_comp_inserted |-> INDEP_CLOCKS && o_tx_word_valid &&
        o_tx_word == {LANES{`LCC_COMP_WORD}}) else $error("bad comp word");
    chk_comp_period: assert property (o_tx_comp_inserted && nins_reg == 2'h2 |->
        gap_reg == PER - 1) else $error("comp spacing wrong");
    chk_comp_not_late: assert property (nins_reg == 2'h2 |-> gap_reg < PER)
        else $error("comp overdue");
    // With a shared clock the pattern is ordinary payload
    chk_rx_no_comp: assert property (o_rx_valid |-> !o_rx_comp_dropped &&
        $past(o_link_ready) && (!INDEP_CLOCKS || o_rx_data != {LANES{`LCC_COMP_WORD}}))
        else $error("comp word delivered");
    chk_rx_one_edge: assert property ((o_rx_valid || o_rx_comp_dropped) |=>
        !(o_rx_valid || o_rx_comp_dropped) [*4]) else $error("rx pulses too close");
    cov_comp_steady: cover property (o_tx_comp_inserted && nins_reg == 2'h2);
    cov_comp_drop: cover property (o_rx_comp_dropped);
    cov_rx_word: cover property (o_rx_valid);
endmodule : lcc_top_sva

bind lcc_top lcc_top_sva #(.LANES(LANES), .INDEP_CLOCKS(INDEP_CLOCKS), .TOL_100PPM(TOL_100PPM),
    .COMP_CYC_300(COMP_CYC_300), .COMP_CYC_100(COMP_CYC_100)) u_sva (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .o_pll_async_reset_out(o_pll_async_reset_out),
    .o_receiver_analog_reset_out(o_receiver_analog_reset_out), .o_link_ready(o_link_ready),
    .o_tx_word_valid(o_tx_word_valid), .o_tx_word(o_tx_word),
    .o_tx_comp_inserted(o_tx_comp_inserted), .o_rx_valid(o_rx_valid),
    .o_rx_data(o_rx_data), .o_rx_comp_dropped(o_rx_comp_dropped));

// ===== bench/lcc_top_tb_top.sv
// Testbench for lcc_top with independent clocks and a short compensation period.
// Assumes the checker is bound and the far end model drives the receive pins.
`timescale 1ns/10ps
`include "lcc_defs.svh"
module lcc_top_tb_top;
    localparam int W = `LCC_LANE_W;
    localparam int PER = 17;
    logic i_clk_sys, i_rst_n, i_pll_locked, i_tx_valid, i_rx_rec_clk, en, sent;
    logic [W-1:0] i_tx_data, i_rx_word, sent_word, o_tx_word, o_rx_data, lfsr;
    logic o_pll_async_reset_out, o_receiver_analog_reset_out, o_link_ready, o_tx_ready;
    logic o_tx_word_valid, o_tx_comp_inserted, o_rx_valid, o_rx_comp_dropped;
    logic [W-1:0] tx_q[$], rx_q[$];
    int errors, checks_done, drops, gap, nins, fill_n, k;
    lcc_top #(.LANES(1), .INDEP_CLOCKS(1'b1), .TOL_100PPM(1'b0), .COMP_CYC_300(PER),
        .COMP_CYC_100(50)) dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_pll_locked(i_pll_locked), .o_pll_async_reset_out(o_pll_async_reset_out),
        .o_receiver_analog_reset_out(o_receiver_analog_reset_out), .o_link_ready(o_link_ready),
        .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready),
        .o_tx_word_valid(o_tx_word_valid), .o_tx_word(o_tx_word),
        .o_tx_comp_inserted(o_tx_comp_inserted), .i_rx_rec_clk(i_rx_rec_clk),
        .i_rx_word(i_rx_word), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
        .o_rx_comp_dropped(o_rx_comp_dropped));
    lcc_far_end #(.EVERY(5)) u_far (.i_en(en), .o_rec_clk(i_rx_rec_clk), .o_word(i_rx_word),
        .o_sent(sent), .o_sent_word(sent_word));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task check(input string name, input logic [W-1:0] exp, input logic [W-1:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task summarize;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // One word per three cycles: the registered ready lags a cycle, so it must
    // catch up with the last push before the next word is offered
    task push(input logic [W-1:0] d);
        tx_q.push_back(d);
        @(posedge i_clk_sys) begin
            i_tx_valid <= 1'b1;
            i_tx_data <= d;
        end
        @(posedge i_clk_sys) i_tx_valid <= 1'b0;
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask : push
    // System clock from its own source, not a transceiver pad
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    always @(sent) if (en === 1'b1) rx_q.push_back(sent_word);
    always @(posedge i_clk_sys) begin
        gap++;
        if (o_tx_word_valid === 1'b1 && o_tx_comp_inserted !== 1'b1)
            check("tx_word", tx_q.pop_front(), o_tx_word);
        if (o_tx_comp_inserted === 1'b1) begin
            if (nins >= 2) check("comp_gap", W'(PER), W'(gap));
            nins++;
            gap = 0;
        end
        if (o_rx_valid === 1'b1) check("rx_word", rx_q.pop_front(), o_rx_data);
        if (o_rx_comp_dropped === 1'b1) drops++;
    end
    initial begin
        #50000;
        errors++;
        summarize();
    end
    initial begin
        {i_rst_n, i_pll_locked, i_tx_valid, en, i_tx_data} = '0;
        lfsr = 16'h0061;
        {errors, checks_done, drops, gap, nins, fill_n} = '0;
        repeat (16) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (4) @(negedge i_clk_sys);
        for (int i = 0; i < 4; i++) if (o_tx_ready === 1'b1) begin
            push(16'h0A00 + 16'(i));
            fill_n++;
        end
        check("fill", W'(2), W'(fill_n));
        check("tx_ready", '0, W'(o_tx_ready));
        repeat (56) @(negedge i_clk_sys);
        // PLL reset ends after its hold time; the receiver reset waits for lock
        check("pll_wait", '0, W'(o_pll_async_reset_out));
        check("rx_wait", W'(1), W'(o_receiver_analog_reset_out));
        @(posedge i_clk_sys) i_pll_locked <= 1'b1;
        for (k = 0; k < 200 && o_link_ready !== 1'b1; k++) @(negedge i_clk_sys);
        check("rx_hold", W'(1), W'(k >= 40 && o_link_ready === 1'b1));
        en <= 1'b1;
        for (int i = 0; i < 30; i++) begin
            for (k = 0; k < 50 && o_tx_ready !== 1'b1; k++) @(negedge i_clk_sys);
            lfsr = lfsr_next(lfsr);
            push(lfsr);
        end
        repeat (200) @(negedge i_clk_sys);
        en <= 1'b0;
        repeat (20) @(negedge i_clk_sys);
        check("tx_left", '0, W'(tx_q.size()));
        check("rx_left", '0, W'(rx_q.size()));
        check("drops", W'(1), W'(drops > 0));
        check("inserts", W'(1), W'(nins > 3));
        summarize();
    end
endmodule : lcc_top_tb_top

// ===== design/lcc_buf.sv
// Two-entry valid/ready buffer in the transmit data path.
// Assumes a single clock; ready on the fill side comes from a flip-flop.
`timescale 1ns/10ps
module lcc_buf #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Streams
    lcc_stream_if.snk s_in,
    lcc_stream_if.src s_out
);
    logic [W-1:0] mem_reg [2];
    logic [1:0] cnt_reg;
    logic rd_reg;
    logic wr_reg;
    logic rdy_reg;
    logic push;
    logic pop;
    logic [1:0] cnt_next;

    // Ready is registered, so a full buffer still refuses in the cycle of a pop
    assign push = s_in.valid & rdy_reg;
    assign pop = s_out.ready & (cnt_reg != 2'h0);
    assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    assign s_in.ready = rdy_reg;
    assign s_out.valid = (cnt_reg != 2'h0);
    assign s_out.data = mem_reg[rd_reg];

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cnt_reg <= 2'h0;
            rdy_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            rdy_reg <= (cnt_next != 2'h2);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_reg <= ~wr_reg;
            end
            if (pop) begin
                rd_reg <= ~rd_reg;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_reg[wr_reg] <= s_in.data;
        end
    end
endmodule : lcc_buf

// ===== design/lcc_defs.svh
// Constants for the link clock compensation block: timing, field widths, codes.
// Assumes the includer works on the 40 MHz system clock.
//
// What this block does
// - Each system clock cycle carries twenty line bits on every lane, so the line rate is 20 times the clock.
// - All lanes share one clock and one word rate, so raw bandwidth grows with the lane count.
// - All logic, the receive front end included, runs on the single system clock.
// - Receive data sampled at recovered clock rising edges reaches the system domain through a synchroniser crossing without loss.
// - With one shared clock source, the default, no compensation insertion or removal logic exists.
// - With independent clocks of equal nominal rate, compensation keeps a slightly faster sender from losing data.
// - At 300 ppm tolerance, the default, a compensation sequence is inserted every 1667 system clock cycles.
// - At 100 ppm tolerance, one is inserted every 5000 cycles; tolerance matters only with independent clocks.
// - A reset state machine on the system clock drives the transceiver PLL reset and receiver analog reset.
// - Reversed lane polarity and reversed lane order may be corrected automatically; this block passes lanes in wired order and polarity.
`ifndef LCC_DEFS_SVH
`define LCC_DEFS_SVH

// ----------------------------------------
// Clock and line rate
// ----------------------------------------
`define LCC_CLK_PERIOD_NS 25
`define LCC_LINE_BITS_PER_CLK 20
`define LCC_LANE_W 16

// ----------------------------------------
// Compensation spacing, system clock cycles
// ----------------------------------------
`define LCC_COMP_CYC_300PPM 1667
`define LCC_COMP_CYC_100PPM 5000
`define LCC_COMP_CNT_W 13
`define LCC_COMP_WORD 16'hBC1C

// ----------------------------------------
// Reset sequencing times
// ----------------------------------------
`define LCC_PLL_RST_NS 1000
`define LCC_RX_RST_NS 1000
`define LCC_PLL_RST_CYC ((`LCC_PLL_RST_NS + `LCC_CLK_PERIOD_NS - 1) / `LCC_CLK_PERIOD_NS)
`define LCC_RX_RST_CYC ((`LCC_RX_RST_NS + `LCC_CLK_PERIOD_NS - 1) / `LCC_CLK_PERIOD_NS)
`define LCC_RST_CNT_W 8

`endif

// ===== design/lcc_pkg.sv
// Types for the link clock compensation block.
// Assumes lcc_defs.svh supplies the numbers.
package lcc_pkg;

    // ----------------------------------------
    // Reset sequencer states, Gray along the path
    // ----------------------------------------
    typedef enum logic [1:0] {
        LCC_RST_PLL = 2'h0,
        LCC_RST_LOCK = 2'h1,
        LCC_RST_RX = 2'h3,
        LCC_RST_DONE = 2'h2
    } lcc_rst_state_t;

endpackage : lcc_pkg

// ===== design/lcc_stream_if.sv
// Valid/ready word stream between the block's own modules.
// Assumes both ends share the system clock.
`timescale 1ns/10ps
interface lcc_stream_if #(parameter int W = 16);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : lcc_stream_if

// ===== design/lcc_top.sv
// Link clock compensation: reset sequencer, transmit compensation inserter,
// receive front end and clock crossing.
// Assumes the system clock does not come from an active transceiver's reference pad
// and that the recovered clock is far slower than the system clock.
`timescale 1ns/10ps
`include "lcc_defs.svh"
module lcc_top #(
    parameter int LANES = 1,
    parameter bit INDEP_CLOCKS = 1'b0,
    parameter bit TOL_100PPM = 1'b0,
    parameter int COMP_CYC_300 = `LCC_COMP_CYC_300PPM,
    parameter int COMP_CYC_100 = `LCC_COMP_CYC_100PPM
) (
    // System clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Transceiver status and reset controls
    input wire logic i_pll_locked,
    output logic o_pll_async_reset_out,
    output logic o_receiver_analog_reset_out,
    output logic o_link_ready,
    // Transmit user stream
    input wire logic i_tx_valid,
    input wire logic [LANES*`LCC_LANE_W-1:0] i_tx_data,
    output logic o_tx_ready,
    // Transmit words to the serialisers
    output logic o_tx_word_valid,
    output logic [LANES*`LCC_LANE_W-1:0] o_tx_word,
    output logic o_tx_comp_inserted,
    // Receive side from the deserialisers
    input wire logic i_rx_rec_clk,
    input wire logic [LANES*`LCC_LANE_W-1:0] i_rx_word,
    // Receive user stream
    output logic o_rx_valid,
    output logic [LANES*`LCC_LANE_W-1:0] o_rx_data,
    output logic o_rx_comp_dropped
);
    localparam int W = LANES * `LCC_LANE_W;
    localparam logic [`LCC_COMP_CNT_W-1:0] COMP_LAST =
        TOL_100PPM ? `LCC_COMP_CNT_W'(COMP_CYC_100 - 1) : `LCC_COMP_CNT_W'(COMP_CYC_300 - 1);
    localparam logic [`LCC_RST_CNT_W-1:0] PLL_LAST = `LCC_RST_CNT_W'(`LCC_PLL_RST_CYC - 1);
    localparam logic [`LCC_RST_CNT_W-1:0] RX_LAST = `LCC_RST_CNT_W'(`LCC_RX_RST_CYC - 1);

    // Same compensation pattern on every lane
    function automatic logic [W-1:0] comp_pattern();
        comp_pattern = {LANES{`LCC_COMP_WORD}};
    endfunction : comp_pattern

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic lock_s1_reg;
    logic lock_s2_reg;
    logic rclk_s1_reg;
    logic rclk_s2_reg;
    logic rclk_s3_reg;
    logic [W-1:0] rdat_s1_reg;
    logic [W-1:0] rdat_s2_reg;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            lock_s1_reg <= 1'b0;
            lock_s2_reg <= 1'b0;
        end else begin
            lock_s1_reg <= i_pll_locked;
            lock_s2_reg <= lock_s1_reg;
        end
    end

    // Clock and data share the same delay, so data stays aligned to the sampled edge
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rclk_s1_reg <= 1'b0;
            rclk_s2_reg <= 1'b0;
            rclk_s3_reg <= 1'b0;
            rdat_s1_reg <= '0;
            rdat_s2_reg <= '0;
        end else begin
            rclk_s1_reg <= i_rx_rec_clk;
            rclk_s2_reg <= rclk_s1_reg;
            rclk_s3_reg <= rclk_s2_reg;
            rdat_s1_reg <= i_rx_word;
            rdat_s2_reg <= rdat_s1_reg;
        end
    end

    // ----------------------------------------
    // Transceiver reset sequencer
    // ----------------------------------------
    lcc_pkg::lcc_rst_state_t rst_state_reg;
    logic [`LCC_RST_CNT_W-1:0] rst_cnt_reg;
    logic rst_hit;

    assign rst_hit = (rst_state_reg == lcc_pkg::LCC_RST_PLL) ? (rst_cnt_reg == PLL_LAST)
                                                              : (rst_cnt_reg == RX_LAST);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rst_state_reg <= lcc_pkg::LCC_RST_PLL;
            rst_cnt_reg <= '0;
        end else begin
            case (rst_state_reg)
                lcc_pkg::LCC_RST_PLL: begin
                    rst_cnt_reg <= rst_hit ? '0 : rst_cnt_reg + 1'b1;
                    if (rst_hit) begin
                        rst_state_reg <= lcc_pkg::LCC_RST_LOCK;
                    end
                end
                lcc_pkg::LCC_RST_LOCK: begin
                    rst_cnt_reg <= '0;
                    if (lock_s2_reg) begin
                        rst_state_reg <= lcc_pkg::LCC_RST_RX;
                    end
                end
                lcc_pkg::LCC_RST_RX: begin
                    rst_cnt_reg <= rst_hit ? '0 : rst_cnt_reg + 1'b1;
                    if (!lock_s2_reg) begin
                        rst_state_reg <= lcc_pkg::LCC_RST_PLL;
                        rst_cnt_reg <= '0;
                    end else if (rst_hit) begin
                        rst_state_reg <= lcc_pkg::LCC_RST_DONE;
                    end
                end
                lcc_pkg::LCC_RST_DONE: begin
                    rst_cnt_reg <= '0;
                    // Lost lock restarts the whole sequence
                    if (!lock_s2_reg) begin
                        rst_state_reg <= lcc_pkg::LCC_RST_PLL;
                    end
                end
                default: begin
                    rst_state_reg <= lcc_pkg::LCC_RST_PLL;
                    rst_cnt_reg <= '0;
                end
            endcase
        end
    end

    // Outputs lag the state by one cycle to come straight from flip-flops
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_pll_async_reset_out <= 1'b1;
            o_receiver_analog_reset_out <= 1'b1;
            o_link_ready <= 1'b0;
        end else begin
            o_pll_async_reset_out <= (rst_state_reg == lcc_pkg::LCC_RST_PLL);
            o_receiver_analog_reset_out <= (rst_state_reg != lcc_pkg::LCC_RST_DONE);
            o_link_ready <= (rst_state_reg == lcc_pkg::LCC_RST_DONE);
        end
    end

    // ----------------------------------------
    // Transmit buffer
    // ----------------------------------------
    lcc_stream_if #(.W(W)) tx_in_if ();
    lcc_stream_if #(.W(W)) tx_out_if ();

    assign tx_in_if.valid = i_tx_valid;
    assign tx_in_if.data = i_tx_data;

    lcc_buf #(.W(W)) u_tx_buf (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .s_in(tx_in_if.snk),
        .s_out(tx_out_if.src)
    );

    // Registered copy of the buffer's own registered ready
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_tx_ready <= 1'b0;
        end else begin
            o_tx_ready <= tx_in_if.ready;
        end
    end

    // ----------------------------------------
    // Compensation timer and inserter
    // ----------------------------------------
    logic [`LCC_COMP_CNT_W-1:0] comp_cnt_reg;
    logic comp_pend_reg;
    logic comp_hit;
    logic comp_emit;

    // Tying to the parameter lets synthesis remove the timer for a shared clock
    assign comp_hit = INDEP_CLOCKS && (comp_cnt_reg == COMP_LAST);
    assign comp_emit = comp_pend_reg & o_link_ready;
    // A pending sequence blocks data, which is why a fast sender must be buffered
    assign tx_out_if.ready = o_link_ready & ~comp_pend_reg;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !INDEP_CLOCKS) begin
            comp_cnt_reg <= '0;
        end else if (comp_hit) begin
            comp_cnt_reg <= '0;
        end else begin
            comp_cnt_reg <= comp_cnt_reg + 1'b1;
        end
    end

    // A new period that starts as the last sequence leaves is kept pending
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            comp_pend_reg <= 1'b0;
        end else begin
            comp_pend_reg <= comp_hit | (comp_pend_reg & ~comp_emit);
        end
    end

    // One word of twenty line bits per lane leaves in each cycle with a sequence to emit or a word popped from the buffer
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_tx_word_valid <= 1'b0;
            o_tx_word <= '0;
            o_tx_comp_inserted <= 1'b0;
        end else begin
            o_tx_comp_inserted <= comp_emit;
            if (comp_emit) begin
                o_tx_word_valid <= 1'b1;
                o_tx_word <= comp_pattern();
            end else begin
                o_tx_word_valid <= tx_out_if.valid & tx_out_if.ready;
                o_tx_word <= tx_out_if.data;
            end
        end
    end

    // ----------------------------------------
    // Receive front end and crossing
    // ----------------------------------------
    logic rclk_rise;
    logic rx_is_comp;

    assign rclk_rise = rclk_s2_reg & ~rclk_s3_reg;
    assign rx_is_comp = INDEP_CLOCKS && (rdat_s2_reg == comp_pattern());

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rx_valid <= 1'b0;
            o_rx_data <= '0;
            o_rx_comp_dropped <= 1'b0;
        end else begin
            o_rx_valid <= rclk_rise & o_link_ready & ~rx_is_comp;
            o_rx_comp_dropped <= rclk_rise & o_link_ready & rx_is_comp;
            // Lanes pass in wired order and polarity; automatic reversal is optional, not built
            if (rclk_rise) begin
                o_rx_data <= rdat_s2_reg;
            end
        end
    end
endmodule : lcc_top
